// file: common/qsr_pkg.sv
// Behaviour
// - writing one to control bit 15 resets transmit, receive, negotiation
// - control bit 14 loops transmit output back into receive inputs
// - control bit 12 enables negotiation; when clear it does not run
// - control bit 9 restarts negotiation only when enabled, then self-clears
// - status bit 8 always reads one: extended status register present
// - status bit 6 reads one; frames without preamble are accepted
// - status bit 5 shows negotiation complete, zero if running or disabled
// - status bit 4 shows a detected remote fault
// - status bit 3 always reads one: negotiation capable
// - status bit 2 shows a valid link, zero without one
// - status bit 0 always reads one: extended registers present
// - registers reached by clause 22 frames at a configurable address
// - reserved bits read zero; controller writes zero to them
// - reset input takes effect at once; only its release is delayed through the two-stage pipe
`default_nettype none
package qsr_pkg;
  // register map
  localparam logic [4:0]  REG_CTRL         = 5'h00;
  localparam logic [4:0]  REG_STATUS       = 5'h01;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  localparam logic [15:0] STATUS_FIXED     = 16'h0149;
  // control fields
  localparam int          CTRL_SOFT_RESET  = 15;
  localparam int          CTRL_LOOPBACK    = 14;
  localparam int          CTRL_AN_ENABLE   = 12;
  localparam int          CTRL_AN_RESTART  = 9;
  // status fields
  localparam int          STS_EXT_STATUS   = 8;
  localparam int          STS_PRE_SKIP     = 6;
  localparam int          STS_AN_COMPLETE  = 5;
  localparam int          STS_REMOTE_FAULT = 4;
  localparam int          STS_AN_CAPABLE   = 3;
  localparam int          STS_LINK_UP      = 2;
  localparam int          STS_EXT_REGS     = 0;
  // frame layout
  localparam logic [1:0]  OP_READ          = 2'h2;
  localparam logic [1:0]  OP_WRITE         = 2'h1;
  localparam logic [3:0]  HDR_LAST         = 4'hB;
  localparam logic [3:0]  DATA_LAST        = 4'hF;
  localparam int          PIN_STAGES       = 3;
  localparam int          RST_STAGES       = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HDR,
    ST_TA,
    ST_DATA
  } qsr_state_type;

  typedef struct packed {
    logic autoneg_complete;
    logic remote_fault_seen;
    logic link_up;
  } qsr_link_status_type;
endpackage : qsr_pkg
`default_nettype wire

// file: core/qsr_mgmt_regs.sv
`default_nettype none
module qsr_mgmt_regs (
  // clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         reset_in,
  // management pins
  input  wire logic                         mdc_in,
  input  wire logic                         mdio_in,
  output var  logic                         mdio_out,
  output var  logic                         mdio_oe_n_out,
  input  wire logic [4:0]                   phy_addr_in,
  // datapath status
  input  wire qsr_pkg::qsr_link_status_type link_status_in,
  // datapath control
  output var  logic                         core_soft_reset_out,
  output var  logic                         loopback_enable_out,
  output var  logic                         autoneg_enable_out,
  output var  logic                         autoneg_restart_out
);

  // reset and pin synchronisers
  logic [qsr_pkg::RST_STAGES-1:0] rst_pipe_q, rst_pipe_d;
  logic                           rst;
  logic [qsr_pkg::PIN_STAGES-1:0] mdc_s_q, mdc_s_d;
  logic [qsr_pkg::PIN_STAGES-1:0] mdio_s_q, mdio_s_d;
  logic [qsr_pkg::PIN_STAGES-1:0] st_s_q [3];
  logic [qsr_pkg::PIN_STAGES-1:0] st_s_d [3];
  logic [2:0]                     st_f_q, st_f_d;
  logic                           mdc_f_q, mdc_f_d;
  logic                           mdio_f_q, mdio_f_d;
  logic                           mdc_rise;
  logic                           bit_in;
  logic [2:0]                     st_raw;

  assign rst    = reset_in | rst_pipe_q[qsr_pkg::RST_STAGES-1];
  assign st_raw = {link_status_in.autoneg_complete,
                   link_status_in.remote_fault_seen,
                   link_status_in.link_up};

  // edge counts only once stages two and three agree
  assign mdc_rise = (mdc_s_q[1] == mdc_s_q[2]) & mdc_s_q[2] & ~mdc_f_q;
  assign bit_in   = (mdio_s_q[1] == mdio_s_q[2]) ? mdio_s_q[2] : mdio_f_q;

  always_comb begin
    rst_pipe_d = {rst_pipe_q[qsr_pkg::RST_STAGES-2:0], 1'b0};
    mdc_s_d    = {mdc_s_q[qsr_pkg::PIN_STAGES-2:0], mdc_in};
    mdio_s_d   = {mdio_s_q[qsr_pkg::PIN_STAGES-2:0], mdio_in};
    mdc_f_d    = (mdc_s_q[1] == mdc_s_q[2]) ? mdc_s_q[2] : mdc_f_q;
    mdio_f_d   = bit_in;
    for (int i = 0; i < 3; i++) begin
      st_s_d[i] = {st_s_q[i][qsr_pkg::PIN_STAGES-2:0], st_raw[i]};
      st_f_d[i] = (st_s_q[i][1] == st_s_q[i][2]) ? st_s_q[i][2] : st_f_q[i];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rst_pipe_q <= '1;
    end else begin
      rst_pipe_q <= rst_pipe_d;
    end
    mdc_s_q  <= mdc_s_d;
    mdio_s_q <= mdio_s_d;
    st_s_q   <= st_s_d;
    if (rst) begin
      mdc_f_q  <= 1'b0;
      mdio_f_q <= 1'b1;
      st_f_q   <= 3'h0;
    end else begin
      mdc_f_q  <= mdc_f_d;
      mdio_f_q <= mdio_f_d;
      st_f_q   <= st_f_d;
    end
  end

  // register read decode
  function automatic logic [15:0] read_word(input logic [4:0] regad,
                                            input logic       loop,
                                            input logic       autoneg_enable,
                                            input logic [2:0] st);
    logic [15:0] w;
    w = 16'h0000;
    if (regad == qsr_pkg::REG_CTRL) begin
      w[qsr_pkg::CTRL_LOOPBACK]  = loop;
      w[qsr_pkg::CTRL_AN_ENABLE] = autoneg_enable;
    end else if (regad == qsr_pkg::REG_STATUS) begin
      w = qsr_pkg::STATUS_FIXED;
      w[qsr_pkg::STS_AN_COMPLETE]  = st[2] & autoneg_enable;
      w[qsr_pkg::STS_REMOTE_FAULT] = st[1];
      w[qsr_pkg::STS_LINK_UP]      = st[0];
    end
    return w;
  endfunction : read_word

  // frame engine
  qsr_pkg::qsr_state_type state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [11:0] hdr_q, hdr_d;
  logic [15:0] sh_q, sh_d;
  logic        prev_q, prev_d;
  logic        rd_q, rd_d;
  logic        hit_q, hit_d;
  logic [4:0]  regad_q, regad_d;
  logic        mdo_q, mdo_d;
  logic        oe_n_q, oe_n_d;
  logic        loop_q, loop_d;
  logic        autoneg_enable_q, autoneg_enable_d;
  logic        srst_q, srst_d;
  logic        rstrt_q, rstrt_d;
  logic [15:0] wdata;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    hdr_d   = hdr_q;
    sh_d    = sh_q;
    prev_d  = prev_q;
    rd_d    = rd_q;
    hit_d   = hit_q;
    regad_d = regad_q;
    mdo_d   = mdo_q;
    oe_n_d  = oe_n_q;
    loop_d  = loop_q;
    autoneg_enable_d = autoneg_enable_q;
    srst_d  = 1'b0;
    rstrt_d = 1'b0;
    wdata   = {sh_q[14:0], bit_in};
    if (mdc_rise) begin
      case (state_q)
        qsr_pkg::ST_IDLE: begin
          prev_d = bit_in;
          if (!prev_q && bit_in) begin
            state_d = qsr_pkg::ST_HDR;
            cnt_d   = 4'h0;
          end
        end
        qsr_pkg::ST_HDR: begin
          hdr_d = {hdr_q[10:0], bit_in};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == qsr_pkg::HDR_LAST) begin
            // address match and clause 22 opcode
            rd_d    = hdr_d[11:10] == qsr_pkg::OP_READ;
            hit_d   = (hdr_d[9:5] == phy_addr_in) &&
                      (hdr_d[11:10] == qsr_pkg::OP_READ ||
                       hdr_d[11:10] == qsr_pkg::OP_WRITE);
            regad_d = hdr_d[4:0];
            state_d = qsr_pkg::ST_TA;
            cnt_d   = 4'h0;
          end
        end
        qsr_pkg::ST_TA: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h0) begin
            // snapshot so a read sees one coherent word
            sh_d = read_word(regad_q, loop_q, autoneg_enable_q, st_f_q);
            if (rd_q && hit_q) begin
              mdo_d  = 1'b0;
              oe_n_d = 1'b0;
            end
          end else begin
            state_d = qsr_pkg::ST_DATA;
            cnt_d   = 4'h0;
            if (rd_q && hit_q) begin
              mdo_d = sh_q[15];
              sh_d  = {sh_q[14:0], 1'b0};
            end
          end
        end
        qsr_pkg::ST_DATA: begin
          cnt_d = cnt_q + 4'h1;
          if (rd_q) begin
            mdo_d = sh_q[15];
            sh_d  = {sh_q[14:0], 1'b0};
          end else begin
            sh_d = wdata;
          end
          if (cnt_q == qsr_pkg::DATA_LAST) begin
            state_d = qsr_pkg::ST_IDLE;
            prev_d  = 1'b1;
            mdo_d   = 1'b1;
            oe_n_d  = 1'b1;
            if (!rd_q && hit_q && regad_q == qsr_pkg::REG_CTRL) begin
              loop_d  = wdata[qsr_pkg::CTRL_LOOPBACK];
              autoneg_enable_d = wdata[qsr_pkg::CTRL_AN_ENABLE];
              srst_d  = wdata[qsr_pkg::CTRL_SOFT_RESET];
              rstrt_d = wdata[qsr_pkg::CTRL_AN_RESTART] &
                        wdata[qsr_pkg::CTRL_AN_ENABLE];
            end
          end
        end
        default: begin
          state_d = qsr_pkg::ST_IDLE;
          oe_n_d  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst) begin
      state_q <= qsr_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      hdr_q   <= 12'h000;
      sh_q    <= 16'h0000;
      prev_q  <= 1'b1;
      rd_q    <= 1'b0;
      hit_q   <= 1'b0;
      regad_q <= 5'h00;
      mdo_q   <= 1'b1;
      oe_n_q  <= 1'b1;
      loop_q  <= qsr_pkg::CTRL_RESET[qsr_pkg::CTRL_LOOPBACK];
      autoneg_enable_q <= qsr_pkg::CTRL_RESET[qsr_pkg::CTRL_AN_ENABLE];
      srst_q  <= 1'b0;
      rstrt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      hdr_q   <= hdr_d;
      sh_q    <= sh_d;
      prev_q  <= prev_d;
      rd_q    <= rd_d;
      hit_q   <= hit_d;
      regad_q <= regad_d;
      mdo_q   <= mdo_d;
      oe_n_q  <= oe_n_d;
      loop_q  <= loop_d;
      autoneg_enable_q <= autoneg_enable_d;
      srst_q  <= srst_d;
      rstrt_q <= rstrt_d;
    end
  end

  assign mdio_out            = mdo_q;
  assign mdio_oe_n_out       = oe_n_q;
  assign core_soft_reset_out = srst_q;
  assign loopback_enable_out = loop_q;
  assign autoneg_enable_out  = autoneg_enable_q;
  assign autoneg_restart_out = rstrt_q;

  // checks
  logic [15:0] ctrl_view, sts_view;
  assign ctrl_view = read_word(qsr_pkg::REG_CTRL, loop_q, autoneg_enable_q, st_f_q);
  assign sts_view  = read_word(qsr_pkg::REG_STATUS, loop_q, autoneg_enable_q, st_f_q);

  sequence s_write_done;
    mdc_rise && state_q == qsr_pkg::ST_DATA &&
    cnt_q == qsr_pkg::DATA_LAST && !rd_q && hit_q;
  endsequence

  sequence s_read_ta;
    mdc_rise && state_q == qsr_pkg::ST_TA && cnt_q == 4'h0 && rd_q && hit_q;
  endsequence

  a_soft_reset_pulse: assert property (@(posedge clk_sys_in) disable iff (rst)
    core_soft_reset_out |=> !core_soft_reset_out && !ctrl_view[15])
    else $error("soft reset not a single pulse");
  a_loopback_cause: assert property (@(posedge clk_sys_in) disable iff (rst)
    $changed(loopback_enable_out) |-> $past(state_q) == qsr_pkg::ST_DATA)
    else $error("loopback changed without a write");
  a_enable_cause: assert property (@(posedge clk_sys_in) disable iff (rst)
    s_write_done ##0 (regad_q == qsr_pkg::REG_CTRL)
    |=> autoneg_enable_out == $past(wdata[qsr_pkg::CTRL_AN_ENABLE]))
    else $error("enable not taken from write");
  a_restart_gated: assert property (@(posedge clk_sys_in) disable iff (rst)
    autoneg_restart_out |-> autoneg_enable_out ##1 !autoneg_restart_out)
    else $error("restart while disabled or held");
  a_ext_status_one: assert property (@(posedge clk_sys_in) disable iff (rst)
    sts_view[8])
    else $error("extended status bit low");
  a_preamble_skip: assert property (@(posedge clk_sys_in) disable iff (rst)
    sts_view[6])
    else $error("preamble skip bit low");
  a_complete_gated: assert property (@(posedge clk_sys_in) disable iff (rst)
    sts_view[5] |-> autoneg_enable_q && st_f_q[2])
    else $error("complete shown while disabled");
  a_fault_shown: assert property (@(posedge clk_sys_in) disable iff (rst)
    sts_view[4] == st_f_q[1])
    else $error("remote fault mismatch");
  a_capable_one: assert property (@(posedge clk_sys_in) disable iff (rst)
    sts_view[3] && sts_view[0])
    else $error("capability bits low");
  a_link_shown: assert property (@(posedge clk_sys_in) disable iff (rst)
    sts_view[2] == st_f_q[0] && sts_view[15:9] == 7'h00)
    else $error("link bit mismatch");
  a_read_turn: assert property (@(posedge clk_sys_in) disable iff (rst)
    s_read_ta |=> !mdio_oe_n_out && !mdio_out)
    else $error("turnaround not driven low");
  a_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (rst)
    (ctrl_view & 16'h2DFF) == 16'h0000 && !ctrl_view[15])
    else $error("reserved control bits set");
  a_reset_sync: assert property (@(posedge clk_sys_in)
    reset_in |=> rst_pipe_q[qsr_pkg::RST_STAGES-1] ##1 rst)
    else $error("reset not synchronised");

endmodule : qsr_mgmt_regs
`default_nettype wire

// file: tb/qsr_mdio_ctrl.sv
`default_nettype none
module qsr_mdio_ctrl (
  // clock
  input  wire logic clk_in,
  // management pins
  input  wire logic mdio_in,
  output var  logic mdc_out,
  output var  logic mdio_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // six cycles per phase, margin over the three the device needs
  localparam int HALF = 6;

  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
  end

  task automatic clk_bit(input logic b, output logic s);
    mdio_out <= b;
    repeat (HALF) @(posedge clk_in);
    s = mdio_in;
    mdc_out <= 1'b1;
    repeat (HALF) @(posedge clk_in);
    mdc_out <= 1'b0;
  endtask : clk_bit

  // clause 22 frame, reserved bits left to caller
  task automatic frame(input int pre, input logic [1:0] op,
                       input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] w;
    logic        s;
    // released line floats to the pull-up during a read
    w = {2'b01, op, pa, ra, (op == 2'h2) ? 18'h3FFFF : {2'b10, wd}};
    repeat (pre) clk_bit(1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      clk_bit(w[i], s);
      if (i < 16) rd[i] = s;
    end
    mdio_out <= 1'b1;
  endtask : frame
endmodule : qsr_mdio_ctrl
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", nm, e, g); n_fail++; end end
  localparam logic [4:0] PA = 5'h0A;

  logic                         clk_sys_in = 1'b0;
  logic                         reset_in   = 1'b1;
  logic [4:0]                   phy_addr_in;
  qsr_pkg::qsr_link_status_type link_status_in;
  logic                         mdc, m_sda, mdio_o, oe_n;
  logic                         c_rst, c_lb, c_an, c_rs;
  wire                          mdio_w;
  logic [15:0]                  lfsr, rd, d;
  int                           n_fail, n_tests, n_rst, n_rs, n_oe;
  int                           p0, q0, o0;

  always #2.5 clk_sys_in = ~clk_sys_in;
  // open drain with pull-up: either party may pull low
  assign mdio_w = m_sda & (oe_n ? 1'b1 : mdio_o);

  always @(posedge clk_sys_in) begin
    n_rst += int'(c_rst === 1'b1);
    n_rs  += int'(c_rs === 1'b1);
    n_oe  += int'(oe_n === 1'b0);
  end

  qsr_mgmt_regs qsr_mgmt_regs_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .mdc_in(mdc),
    .mdio_in(mdio_w), .mdio_out(mdio_o), .mdio_oe_n_out(oe_n),
    .phy_addr_in(phy_addr_in), .link_status_in(link_status_in),
    .core_soft_reset_out(c_rst), .loopback_enable_out(c_lb),
    .autoneg_enable_out(c_an), .autoneg_restart_out(c_rs));

  qsr_mdio_ctrl qsr_mdio_ctrl_inst (
    .clk_in(clk_sys_in), .mdio_in(mdio_w), .mdc_out(mdc),
    .mdio_out(m_sda));

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt

  function automatic logic [15:0] exp_sts(input logic [2:0] ls,
                                          input logic an);
    logic [15:0] v;
    v = 16'h0149;
    v[5] = ls[2] & an;
    v[4] = ls[1];
    v[2] = ls[0];
    return v;
  endfunction : exp_sts

  task automatic wr(input logic [4:0] pa, ra, input logic [15:0] v);
    logic [15:0] x;
    qsr_mdio_ctrl_inst.frame(0, 2'h1, pa, ra, v, x);
    repeat (2) @(posedge clk_sys_in);
  endtask : wr

  task automatic rdr(input logic [4:0] pa, ra, input int pre);
    qsr_mdio_ctrl_inst.frame(pre, 2'h2, pa, ra, 16'hFFFF, rd);
    repeat (2) @(posedge clk_sys_in);
  endtask : rdr

  task automatic results;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (100000) @(posedge clk_sys_in);
    n_fail++;
    $display("BAD watchdog exp 0 got 1");
    results();
  end

  initial begin
    phy_addr_in <= PA;
    link_status_in <= '0;
    lfsr = 16'h13C6;
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rdr(PA, 5'h00, 32);
    `CHK("ctrl", 16'h0000, rd)
    rdr(PA, 5'h01, 0);
    `CHK("sts", 16'h0149, rd)
    $display("test reset values done");
    wr(PA, 5'h00, 16'h5000);
    `CHK("loop", 1'b1, c_lb)
    `CHK("an", 1'b1, c_an)
    p0 = n_rst;
    q0 = n_rs;
    wr(PA, 5'h00, 16'hD200);
    `CHK("rst pulses", 1, n_rst - p0)
    `CHK("restart pulses", 1, n_rs - q0)
    rdr(PA, 5'h00, 0);
    `CHK("self clear", 16'h5000, rd)
    wr(PA, 5'h00, 16'h4200);
    `CHK("restart off", 1, n_rs - q0)
    `CHK("an off", 1'b0, c_an)
    $display("test control bits done");
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      link_status_in <= lfsr[2:0];
      d = lfsr & 16'h5000;
      wr(PA, 5'h00, d);
      `CHK("loop rnd", d[14], c_lb)
      rdr(PA, 5'h00, lfsr[3] ? 32 : 0);
      `CHK("ctrl rnd", d, rd)
      rdr(PA, 5'h01, lfsr[4] ? 32 : 0);
      `CHK("sts rnd", exp_sts(lfsr[2:0], d[12]), rd)
    end
    $display("test status random done");
    o0 = n_oe;
    rdr(PA ^ 5'h01, 5'h00, 0);
    `CHK("no drive", 0, n_oe - o0)
    // inverted bits so a wrongly taken write always shows
    wr(PA ^ 5'h10, 5'h00, d ^ 16'h5000);
    wr(PA, 5'h01, d ^ 16'h5000);
    rdr(PA, 5'h00, 0);
    `CHK("foreign write", d, rd)
    rdr(PA, 5'h02, 0);
    `CHK("unmapped", 16'h0000, rd)
    $display("test address refusal done");
    wr(PA, 5'h00, 16'h5000);
    reset_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    `CHK("lb after rst", 1'b0, c_lb)
    rdr(PA, 5'h00, 0);
    `CHK("ctrl after rst", 16'h0000, rd)
    $display("test mid reset done");
    results();
  end
endmodule : testbench
`default_nettype wire
